// File: dv/lswb_pos_src.sv
// position feedback source feeding one sample per request
`timescale 1ns/1ps
module lswb_pos_src (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] pos_i,
    input wire logic send_i,
    output logic [31:0] position_feedback_o,
    output logic position_valid_o
);
    // stale bus shows the inverse of the last value
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            position_feedback_o <= 32'h0;
            position_valid_o <= 1'b0;
        end else if (send_i) begin
            position_feedback_o <= pos_i;
            position_valid_o <= 1'b1;
        end else begin
            position_feedback_o <= ~position_feedback_o;
            position_valid_o <= 1'b0;
        end
    end
endmodule

// File: dv/lswb_top_chk.sv
// assertions on the ports of the limit switch bank
`timescale 1ns/1ps
module lswb_top_chk
    import lswb_pkg::*;
#(
    parameter int TICK_CYCLES = LSWB_TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [LSWB_ADDR_W-1:0] addr_i,
    input wire logic [LSWB_DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [LSWB_DATA_W-1:0] rd_data_o,
    input wire logic [LSWB_POS_W-1:0] position_feedback_i,
    input wire logic position_valid_i,
    input wire logic [LSWB_NUM_SW-1:0] switch_status_flags_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // read data zero outside the answer cycle
    a_rd_idle_zero:
    assert property (!$past(rd_i) |-> rd_data_o == LSWB_RD_ZERO)
        else $error("read data outside answer cycle");
    // status read shows the flags
    a_status_read:
    assert property ($past(rd_i) && $past(addr_i) == LSWB_OFS_STATUS
        |-> rd_data_o == {24'h0, $past(switch_status_flags_o)})
        else $error("status read differs from flags");
    // vector registers are eight bits wide
    a_vec_upper_zero:
    assert property ($past(rd_i) && $past(addr_i) < LSWB_OFS_TRIG_BASE
        |-> rd_data_o[31:8] == 24'h0)
        else $error("vector read upper bits set");
    // rearm and unmapped places read zero
    a_rearm_unmap_zero:
    assert property ($past(rd_i) && ($past(addr_i) == LSWB_OFS_REARM
        || $past(addr_i) >= 8'h80) |-> rd_data_o == LSWB_RD_ZERO)
        else $error("rearm or unmapped read not zero");
    // pulse time never above its ceiling
    a_time_ceiling:
    assert property ($past(rd_i) && $past(addr_i[7:5]) == 3'h3
        |-> rd_data_o <= {15'h0, LSWB_TIME_MAX})
        else $error("pulse time above ceiling");
    // a disabled switch is never active
    a_enable_gate:
    assert property ($past(rd_i) && $past(addr_i) == LSWB_OFS_ENABLE
        |-> (switch_status_flags_o & ~rd_data_o[7:0]) == 8'h00)
        else $error("disabled switch active");
    // flags rise only on a position sample
    a_rise_on_sample:
    assert property ((switch_status_flags_o
        & ~$past(switch_status_flags_o)) != 8'h00 |-> $past(position_valid_i))
        else $error("flag rose without sample");
    // interrupt rises after a flag rise or a write
    a_irq_cause:
    assert property ($rose(irq_o) |-> $past(wr_i, 2)
        || ((switch_status_flags_o & ~$past(switch_status_flags_o))
        != 8'h00))
        else $error("interrupt rose without cause");
endmodule

bind lswb_top lswb_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .position_feedback_i(position_feedback_i),
    .position_valid_i(position_valid_i),
    .switch_status_flags_o(switch_status_flags_o), .irq_o(irq_o));

// File: dv/programmable_limit_switch_bank_test.sv
// register and position tests of the limit switch bank
`timescale 1ns/1ps
module programmable_limit_switch_bank_test;
    import lswb_pkg::*;
    localparam int TC = 20; // short millisecond
    logic clk_sys_i, sys_rst_i, wr_i, rd_i, s_go, fb_v, irq;
    logic [7:0] addr_i, flags;
    logic [31:0] wr_data_i, s_pos, rd_data_o, fb;
    int error_cnt, tests_run, n, i;
    lswb_pos_src src_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .pos_i(s_pos), .send_i(s_go), .position_feedback_o(fb),
        .position_valid_o(fb_v));
    lswb_top #(.TICK_CYCLES(TC)) dut_u (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .position_feedback_i(fb), .position_valid_i(fb_v),
        .switch_status_flags_o(flags), .irq_o(irq));
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one cycle write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    // read, data checked in the answer cycle
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(rd_data_o, e);
    endtask
    // one position sample, flags settled on return
    task samp(input logic [31:0] p);
        @(posedge clk_sys_i);
        s_pos <= p;
        s_go <= 1'b1;
        @(posedge clk_sys_i);
        s_go <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk_sys_i);
        #1;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        sys_rst_i = 1'b1;
        {wr_i, rd_i, s_go, addr_i, wr_data_i, s_pos} = '0;
        error_cnt = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        // reset values, then pulse time saturation
        rd(LSWB_OFS_ENABLE, 32'h0);
        rd(LSWB_OFS_SINGLE, 32'h0);
        rd(LSWB_OFS_HANDLING, 32'h0);
        rd(LSWB_OFS_STATUS, 32'h0);
        rd(LSWB_OFS_ARMED, 32'hff);
        rd(8'h80, 32'h0);
        for (i = 0; i < 8; i++) begin
            rd(LSWB_OFS_TRIG_BASE + 8'(4 * i), 32'h0);
            rd(LSWB_OFS_WIDTH_BASE + 8'(4 * i), 32'h0);
            rd(LSWB_OFS_TIME_BASE + 8'(4 * i), 32'h1f4);
        end
        wr(LSWB_OFS_TIME_BASE, 32'h2_0000);
        rd(LSWB_OFS_TIME_BASE, 32'h1_0000);
        $display("test reset done");
        // one window per switch, edges inclusive
        wr(LSWB_OFS_ENABLE, 32'hff);
        for (i = 0; i < 8; i++) begin
            wr(LSWB_OFS_TRIG_BASE + 8'(4 * i), 32'(100 * i));
            wr(LSWB_OFS_WIDTH_BASE + 8'(4 * i), 32'd50);
            wr(LSWB_OFS_TIME_BASE + 8'(4 * i), 32'd3);
        end
        for (i = 0; i < 8; i++) begin
            samp(32'(100 * i - 1));
            chk(flags, 8'h00);
            samp(32'(100 * i));
            chk(flags, 8'h01 << i);
            samp(32'(100 * i + 50));
            chk(flags, 8'h01 << i);
            samp(32'(100 * i + 51));
            chk(flags, 8'h00);
        end
        samp(32'd350);
        tick(4 * TC);
        chk(flags, 8'h08);
        rd(LSWB_OFS_STATUS, 32'h08);
        wr(LSWB_OFS_WIDTH_BASE, 32'h0);
        samp(32'd5000);
        chk(flags, 8'h01);
        wr(LSWB_OFS_ENABLE, 32'hfe);
        tick(1);
        chk(flags, 8'h00);
        $display("test window done");
        // timed pulse on switch 1
        samp(32'h0);
        wr(LSWB_OFS_HANDLING, 32'h02);
        samp(32'd220);
        chk(flags, 8'h06);
        for (n = 0; n < 200 && flags[1] === 1'b1; n++) tick(1);
        chk(32'(n < 200), 32'h1);
        chk(n >= 2 * TC && n <= 3 * TC + 1, 1'b1);
        chk(flags, 8'h04);
        samp(32'h0);
        chk(flags, 8'h02);
        $display("test pulse done");
        // single shot, rearm and interrupt
        wr(LSWB_OFS_HANDLING, 32'h0);
        wr(LSWB_OFS_ENABLE, 32'hff);
        wr(LSWB_OFS_SINGLE, 32'h01);
        samp(32'hffff_ffff);
        wr(LSWB_OFS_IRQ_STAT, 32'hff);
        wr(LSWB_OFS_IRQ_MASK, 32'h01);
        samp(32'h1);
        chk(flags, 8'h01);
        tick(1);
        chk(irq, 1'b1);
        rd(LSWB_OFS_ARMED, 32'hfe);
        wr(LSWB_OFS_IRQ_STAT, 32'h01);
        tick(1);
        chk(irq, 1'b0);
        samp(32'hffff_ffff);
        samp(32'h1);
        chk(flags, 8'h00);
        wr(LSWB_OFS_REARM, 32'h01);
        wr(LSWB_OFS_IRQ_MASK, 32'h0);
        samp(32'hffff_ffff);
        samp(32'h1);
        chk(flags, 8'h01);
        tick(1);
        chk(irq, 1'b0);
        rd(LSWB_OFS_IRQ_STAT, 32'h01);
        $display("test single shot done");
        close_out;
    end
endmodule

// File: verilog/lswb_ms_tick.sv
// free running divider giving a one cycle millisecond tick
`timescale 1ns/1ps
module lswb_ms_tick
    import lswb_pkg::*;
#(
    parameter int TICK_CYCLES = LSWB_TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    output logic tick_o
);
    localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);
    logic [31:0] count; // cycles since last tick

    // count up one period, pulse at the wrap
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= '0;
            tick_o <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            tick_o <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: verilog/lswb_pkg.sv
// constants, offsets and reset values of the limit switch bank
package lswb_pkg;
    // bank geometry
    localparam int LSWB_NUM_SW = 8;
    localparam int LSWB_DATA_W = 32;
    localparam int LSWB_ADDR_W = 8;
    localparam int LSWB_POS_W = 32;
    localparam int LSWB_TIME_W = 17;
    // clock and millisecond base
    localparam int LSWB_CLK_HZ = 20000000;
    localparam int LSWB_TICK_MS = 1;
    localparam int LSWB_TICK_CYCLES = LSWB_CLK_HZ / 1000 * LSWB_TICK_MS;
    // register byte addresses
    localparam logic [7:0] LSWB_OFS_ENABLE = 8'h00;
    localparam logic [7:0] LSWB_OFS_SINGLE = 8'h04;
    localparam logic [7:0] LSWB_OFS_HANDLING = 8'h08;
    localparam logic [7:0] LSWB_OFS_REARM = 8'h0c;
    localparam logic [7:0] LSWB_OFS_STATUS = 8'h10;
    localparam logic [7:0] LSWB_OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] LSWB_OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] LSWB_OFS_ARMED = 8'h1c;
    localparam logic [7:0] LSWB_OFS_TRIG_BASE = 8'h20;
    localparam logic [7:0] LSWB_OFS_WIDTH_BASE = 8'h40;
    localparam logic [7:0] LSWB_OFS_TIME_BASE = 8'h60;
    // per switch array geometry: 8 words of 4 bytes
    localparam logic [7:0] LSWB_ARRAY_MASK = 8'he0;
    localparam int LSWB_IDX_LSB = 2;
    localparam int LSWB_IDX_W = 3;
    // reset values, pulse time ceiling and step
    localparam logic [7:0] LSWB_RST_VEC = 8'h00;
    localparam logic [31:0] LSWB_RST_POS = 32'h0000_0000;
    localparam logic [16:0] LSWB_RST_TIME = 17'h001f4;
    localparam logic [16:0] LSWB_TIME_MAX = 17'h10000;
    localparam logic [16:0] LSWB_TIME_ZERO = 17'h00000;
    localparam logic [16:0] LSWB_TIME_ONE = 17'h00001;
    localparam logic [31:0] LSWB_RD_ZERO = 32'h0000_0000;
endpackage

// File: verilog/lswb_top.sv
// bank of eight programmable limit switches with register port
// Behaviour
// - status vector, bit i is switch i
// - pulse time per switch, 0..65536 ms, 500 reset
// - pulse time used only in time mode
// - handling select vector, reset zero
// - position mode: active inside inclusive window
// - zero width: active at or above trigger
// - time mode: pulse for time after crossing
// - window width per switch, reset zero
// - enable vector, clear bit disables switch
// - single shot stops monitoring after trigger
// - rearm write re-arms single shot switch
// - trigger point per switch, reset zero
`timescale 1ns/1ps
module lswb_top
    import lswb_pkg::*;
#(
    parameter int TICK_CYCLES = LSWB_TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [LSWB_ADDR_W-1:0] addr_i,
    input wire logic [LSWB_DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [LSWB_DATA_W-1:0] rd_data_o,
    input wire logic [LSWB_POS_W-1:0] position_feedback_i,
    input wire logic position_valid_i,
    output logic [LSWB_NUM_SW-1:0] switch_status_flags_o,
    output logic irq_o
);
    // software visible state
    logic [7:0] switch_enable_mask; // one enable per switch
    logic [7:0] single_shot_select; // one single shot bit per switch
    logic [7:0] switch_handling_select; // set means time based
    logic [7:0] irq_status; // sticky rise events
    logic [7:0] irq_mask; // interrupt gate
    logic [7:0] armed; // single shot observation armed
    logic [7:0] switch_status_flags; // live switch flags
    logic [LSWB_POS_W-1:0] trigger_point [LSWB_NUM_SW];
    logic [LSWB_POS_W-1:0] window_width [LSWB_NUM_SW];
    logic [LSWB_TIME_W-1:0] pulse_time [LSWB_NUM_SW];
    logic [LSWB_TIME_W-1:0] pulse_left [LSWB_NUM_SW]; // ms still to go
    // position history for crossing detection
    logic [LSWB_POS_W-1:0] prev_pos; // previous feedback sample
    logic have_prev; // prev_pos holds a real sample
    // decode helpers
    logic [LSWB_IDX_W-1:0] idx; // array index from address
    logic wr_trig; // write hits trigger point array
    logic wr_width; // write hits window width array
    logic wr_time; // write hits pulse time array
    logic [7:0] rearm_req; // one cycle rearm pulses
    logic [7:0] flag_rise; // flag goes active this cycle
    logic [7:0] next_flag; // next flag values
    logic [7:0] next_armed_clr; // single shot triggered
    logic [LSWB_TIME_W-1:0] next_left [LSWB_NUM_SW];
    logic [LSWB_TIME_W-1:0] time_wr_val; // clamped pulse time
    logic ms_tick; // one pulse per millisecond
    logic [LSWB_DATA_W-1:0] next_rd_data; // read mux result

    // millisecond base for time based pulses
    lswb_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(ms_tick)
    );

    // address decode of the per switch arrays
    assign idx = addr_i[LSWB_IDX_LSB +: LSWB_IDX_W];
    assign wr_trig = wr_i
        && ((addr_i & LSWB_ARRAY_MASK) == LSWB_OFS_TRIG_BASE);
    assign wr_width = wr_i
        && ((addr_i & LSWB_ARRAY_MASK) == LSWB_OFS_WIDTH_BASE);
    assign wr_time = wr_i
        && ((addr_i & LSWB_ARRAY_MASK) == LSWB_OFS_TIME_BASE);
    assign rearm_req = (wr_i && addr_i == LSWB_OFS_REARM) ?
        wr_data_i[7:0] : LSWB_RST_VEC;
    // values above the top of range saturate at 65536 ms
    assign time_wr_val = (wr_data_i > 32'(LSWB_TIME_MAX)) ?
        LSWB_TIME_MAX : wr_data_i[LSWB_TIME_W-1:0];

    // vector control registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            switch_enable_mask <= LSWB_RST_VEC;
            single_shot_select <= LSWB_RST_VEC;
            switch_handling_select <= LSWB_RST_VEC;
            irq_mask <= LSWB_RST_VEC;
        end else if (wr_i) begin
            case (addr_i)
                LSWB_OFS_ENABLE: begin
                    switch_enable_mask <= wr_data_i[7:0];
                end
                LSWB_OFS_SINGLE: begin
                    single_shot_select <= wr_data_i[7:0];
                end
                LSWB_OFS_HANDLING: begin
                    switch_handling_select <= wr_data_i[7:0];
                end
                LSWB_OFS_IRQ_MASK: begin
                    irq_mask <= wr_data_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // per switch parameter storage
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < LSWB_NUM_SW; i++) begin
                trigger_point[i] <= LSWB_RST_POS;
                window_width[i] <= LSWB_RST_POS;
                pulse_time[i] <= LSWB_RST_TIME;
            end
        end else begin
            if (wr_trig) begin
                trigger_point[idx] <= wr_data_i;
            end
            if (wr_width) begin
                window_width[idx] <= wr_data_i;
            end
            if (wr_time) begin
                pulse_time[idx] <= time_wr_val;
            end
        end
    end

    // feedback history, first sample cannot count as a crossing
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_pos <= LSWB_RST_POS;
            have_prev <= 1'b0;
        end else if (position_valid_i) begin
            prev_pos <= position_feedback_i;
            have_prev <= 1'b1;
        end
    end

    // per switch evaluation
    genvar g;
    generate
        for (g = 0; g < LSWB_NUM_SW; g++) begin : g_sw
            logic signed [LSWB_POS_W:0] pos_s; // sign extended feedback
            logic signed [LSWB_POS_W:0] old_s; // sign extended history
            logic signed [LSWB_POS_W:0] trig_s; // sign extended trigger
            logic signed [LSWB_POS_W:0] top_s; // window upper bound
            logic at_or_above; // feedback at or above trigger
            logic in_window; // feedback inside window
            logic crossed; // trigger passed between two samples
            logic may_fire; // monitoring still allowed

            assign pos_s = {position_feedback_i[LSWB_POS_W-1],
                            position_feedback_i};
            assign old_s = {prev_pos[LSWB_POS_W-1], prev_pos};
            assign trig_s = {trigger_point[g][LSWB_POS_W-1],
                             trigger_point[g]};
            // one extra bit keeps the sum from wrapping
            assign top_s = trig_s + {window_width[g][LSWB_POS_W-1],
                                     window_width[g]};
            assign at_or_above = pos_s >= trig_s;
            // zero width opens the window upward without bound
            assign in_window = at_or_above
                && ((window_width[g] == LSWB_RST_POS)
                    || (pos_s <= top_s));
            // crossing in either direction between two samples
            assign crossed = have_prev
                && (at_or_above != (old_s >= trig_s));
            assign may_fire = !single_shot_select[g] || armed[g];

            // next flag and remaining pulse time
            always_comb begin
                next_flag[g] = switch_status_flags[g];
                next_left[g] = pulse_left[g];
                if (!switch_enable_mask[g]) begin
                    next_flag[g] = 1'b0;
                    next_left[g] = LSWB_TIME_ZERO;
                end else if (!switch_handling_select[g]) begin
                    // position mode ignores the pulse time
                    next_left[g] = LSWB_TIME_ZERO;
                    if (position_valid_i) begin
                        // no new activation once single shot fired
                        next_flag[g] = in_window
                            && (switch_status_flags[g] || may_fire);
                    end
                end else begin
                    if (ms_tick && pulse_left[g] != LSWB_TIME_ZERO) begin
                        next_left[g] = pulse_left[g]
                            - LSWB_TIME_ONE;
                    end
                    if (position_valid_i && crossed && may_fire) begin
                        next_left[g] = pulse_time[g];
                    end
                    next_flag[g] = next_left[g] != LSWB_TIME_ZERO;
                end
            end

            assign flag_rise[g] = next_flag[g] && !switch_status_flags[g];
            assign next_armed_clr[g] = flag_rise[g] && single_shot_select[g];
        end
    endgenerate

    // flags and pulse timers, all switches every cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            switch_status_flags <= LSWB_RST_VEC;
            for (int i = 0; i < LSWB_NUM_SW; i++) begin
                pulse_left[i] <= LSWB_TIME_ZERO;
            end
        end else begin
            switch_status_flags <= next_flag;
            for (int i = 0; i < LSWB_NUM_SW; i++) begin
                pulse_left[i] <= next_left[i];
            end
        end
    end

    // single shot arming, a trigger in the rearm cycle disarms
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            armed <= ~LSWB_RST_VEC; // every switch starts armed
        end else begin
            // disarm wins over a rearm in the same cycle
            armed <= (armed | rearm_req)
                & ~next_armed_clr;
        end
    end

    // sticky interrupt events, new rise wins over clear
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_status <= LSWB_RST_VEC;
        end else if (wr_i && addr_i == LSWB_OFS_IRQ_STAT) begin
            irq_status <= (irq_status & ~wr_data_i[7:0]) | flag_rise;
        end else begin
            irq_status <= irq_status | flag_rise;
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            switch_status_flags_o <= LSWB_RST_VEC;
            irq_o <= 1'b0;
        end else begin
            switch_status_flags_o <= next_flag;
            irq_o <= |(irq_mask & ((irq_status & ~((wr_i
                && addr_i == LSWB_OFS_IRQ_STAT) ? wr_data_i[7:0]
                : LSWB_RST_VEC)) | flag_rise));
        end
    end

    // read multiplexer, unmapped reads return zero
    always_comb begin
        next_rd_data = LSWB_RD_ZERO;
        case (addr_i & LSWB_ARRAY_MASK)
            LSWB_OFS_TRIG_BASE: begin
                next_rd_data = trigger_point[idx];
            end
            LSWB_OFS_WIDTH_BASE: begin
                next_rd_data = window_width[idx];
            end
            LSWB_OFS_TIME_BASE: begin
                next_rd_data = 32'(pulse_time[idx]);
            end
            default: begin
                case (addr_i)
                    LSWB_OFS_ENABLE: next_rd_data[7:0] = switch_enable_mask;
                    LSWB_OFS_SINGLE: next_rd_data[7:0] = single_shot_select;
                    LSWB_OFS_HANDLING: begin
                        next_rd_data[7:0] = switch_handling_select;
                    end
                    LSWB_OFS_STATUS: begin
                        next_rd_data[7:0] = switch_status_flags;
                    end
                    LSWB_OFS_IRQ_STAT: next_rd_data[7:0] = irq_status;
                    LSWB_OFS_IRQ_MASK: next_rd_data[7:0] = irq_mask;
                    LSWB_OFS_ARMED: next_rd_data[7:0] = armed;
                    default: next_rd_data = LSWB_RD_ZERO;
                endcase
            end
        endcase
    end

    // read data stand for one cycle after the strobe
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= LSWB_RD_ZERO;
        end else if (rd_i) begin
            rd_data_o <= next_rd_data;
        end else begin
            rd_data_o <= LSWB_RD_ZERO;
        end
    end
endmodule
